// *** extended_set_enable_bit_pkg.sv ***
// shared constants and carrier types for the extended stack instruction unit
package extended_set_enable_bit_pkg;
	localparam int ADDR_W = 12;
	localparam int PC_W   = 21;

	// opcode patterns: upper bytes, the full call word and the second-word upper nibble
	localparam logic [7:0] OP_ADD_PTR   = 8'hE8;
	localparam logic [7:0] OP_SUB_PTR   = 8'hE9;
	localparam logic [7:0] OP_MOVE_IDX  = 8'hEB;
	localparam logic [7:0] OP_PUSH_LIT  = 8'hFA;
	localparam logic [15:0] OP_CALL_ACC = 16'h0014;
	localparam logic [3:0] OP_SECOND    = 4'hF;

	localparam logic [1:0] SEL_STACK_PTR = 2'h3;
	localparam logic [1:0] SEL_MAX_PTR   = 2'h2;
	localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
	localparam logic [7:0] ZERO_BYTE     = 8'h00;

	// special function addresses
	localparam logic [ADDR_W-1:0] ADDR_PC_LOW  = 12'hFF9;
	localparam logic [ADDR_W-1:0] ADDR_TOS_LOW = 12'hFFD;
	localparam logic [ADDR_W-1:0] ADDR_TOS_HI  = 12'hFFE;
	localparam logic [ADDR_W-1:0] ADDR_TOS_UP  = 12'hFFF;

	// indirect access register addresses, three pointers times five ports
	localparam int N_INDIRECT = 15;
	localparam logic [N_INDIRECT*ADDR_W-1:0] INDIRECT_ADDRS = {
		12'hFEB, 12'hFEC, 12'hFED, 12'hFEE, 12'hFEF,
		12'hFE3, 12'hFE4, 12'hFE5, 12'hFE6, 12'hFE7,
		12'hFDB, 12'hFDC, 12'hFDD, 12'hFDE, 12'hFDF
	};

	localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_NOP       = 3'b001,
		ST_MOVE_FILE = 3'b010,
		ST_MOVE_IDX  = 3'b011
	} exec_state_t;

	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} mem_write_t;

	typedef struct packed {
		logic            push;
		logic [PC_W-1:0] push_value;
		logic            load;
		logic [PC_W-1:0] load_value;
	} flow_t;
endpackage

// *** indirect_addr_detect.sv ***
// flags an address that names an indirect access register
`timescale 1ns/1ps
module indirect_addr_detect (
	input  wire logic [extended_set_enable_bit_pkg::ADDR_W-1:0] i_addr,
	output logic                              o_is_indirect
);
	logic [extended_set_enable_bit_pkg::N_INDIRECT-1:0] hit;

	genvar g;
	generate
		for (g = 0; g < extended_set_enable_bit_pkg::N_INDIRECT; g++) begin : g_cmp
			assign hit[g] = (i_addr == extended_set_enable_bit_pkg::INDIRECT_ADDRS[g*extended_set_enable_bit_pkg::ADDR_W +: extended_set_enable_bit_pkg::ADDR_W]);
		end
	endgenerate

	assign o_is_indirect = |hit;
endmodule

// *** extended_stack_instruction_exec.sv ***
// decode and execute of the extended stack instruction subset
`timescale 1ns/1ps
module extended_stack_instruction_exec (
	input  wire logic                             i_sys_clk,
	input  wire logic                             i_reset_n,
	input  wire logic                             i_extended_set_enable_bit,
	input  wire logic                             i_instr_valid,
	input  wire logic [15:0]                      i_instr_word,
	input  wire logic [extended_set_enable_bit_pkg::PC_W-1:0]       i_program_counter,
	input  wire logic [7:0]                       i_accumulator_register,
	input  wire logic [7:0]                       i_program_counter_high_latch,
	input  wire logic [7:0]                       i_program_counter_upper_latch,
	input  wire logic [extended_set_enable_bit_pkg::PC_W-1:0]       i_return_stack_top,
	input  wire logic [7:0]                       i_mem_rdata,
	output logic                                  o_busy,
	output logic                                  o_handled,
	output logic [extended_set_enable_bit_pkg::ADDR_W-1:0]          o_mem_raddr,
	output extended_set_enable_bit_pkg::mem_write_t                 o_mem_write,
	output extended_set_enable_bit_pkg::flow_t                      o_flow,
	output logic [extended_set_enable_bit_pkg::ADDR_W-1:0]          o_file_select_pointer0,
	output logic [extended_set_enable_bit_pkg::ADDR_W-1:0]          o_file_select_pointer1,
	output logic [extended_set_enable_bit_pkg::ADDR_W-1:0]          o_stack_pointer_register
);
	localparam int AW    = extended_set_enable_bit_pkg::ADDR_W;
	localparam int N_PTR = int'(extended_set_enable_bit_pkg::SEL_MAX_PTR) + 1;

	extended_set_enable_bit_pkg::exec_state_t state_reg;
	logic [AW-1:0]          ptr_reg [0:N_PTR-1];
	logic [AW-1:0]          mem_raddr_reg;
	extended_set_enable_bit_pkg::mem_write_t  mem_write_reg;
	extended_set_enable_bit_pkg::flow_t       flow_reg;
	logic                   busy_reg;
	logic                   handled_reg;
	logic                   src_indirect_reg;

	logic [7:0]  opc;
	logic [1:0]  sel;
	logic [AW-1:0] lit6;
	logic [AW-1:0] off7;
	logic        active;
	logic        is_add;
	logic        is_sub;
	logic        is_move;
	logic        is_push;
	logic        is_call;
	logic        is_second;
	logic        kind_add;
	logic        kind_sub;
	logic        kind_move;
	logic        kind_push;
	logic        ret_form;
	logic        in_move;
	logic [AW-1:0] stack_ptr;
	logic [AW-1:0] dst_file_addr;
	logic [AW-1:0] src_addr;
	logic [AW-1:0] dst_idx_addr;
	logic        src_is_ind;
	logic        dst_is_ind;
	logic [7:0]  move_data;

	// decode fields of the current word
	assign opc       = i_instr_word[15:8];
	assign sel       = i_instr_word[7:6];
	assign lit6      = AW'(i_instr_word[5:0]);
	assign off7      = AW'(i_instr_word[6:0]);
	assign active    = i_instr_valid && i_extended_set_enable_bit && (state_reg == extended_set_enable_bit_pkg::ST_IDLE);
	assign is_add    = active && kind_add;
	assign is_sub    = active && kind_sub;
	assign is_move   = active && kind_move;
	assign is_push   = active && kind_push;
	assign is_call   = active && (i_instr_word == extended_set_enable_bit_pkg::OP_CALL_ACC);
	assign is_second = i_instr_valid && (i_instr_word[15:12] == extended_set_enable_bit_pkg::OP_SECOND);
	// forms that end in a return
	assign ret_form  = is_add || (is_sub && sel == extended_set_enable_bit_pkg::SEL_STACK_PTR);
	assign in_move   = (state_reg == extended_set_enable_bit_pkg::ST_MOVE_FILE) || (state_reg == extended_set_enable_bit_pkg::ST_MOVE_IDX);

	// first-word classification by upper byte
	always_comb begin
		kind_add  = 1'b0;
		kind_sub  = 1'b0;
		kind_move = 1'b0;
		kind_push = 1'b0;
		case (opc)
			extended_set_enable_bit_pkg::OP_ADD_PTR: begin
				// only select three; other selects are not this unit's
				kind_add = (sel == extended_set_enable_bit_pkg::SEL_STACK_PTR);
			end
			extended_set_enable_bit_pkg::OP_SUB_PTR: begin
				kind_sub = 1'b1;
			end
			extended_set_enable_bit_pkg::OP_MOVE_IDX: begin
				kind_move = 1'b1;
			end
			extended_set_enable_bit_pkg::OP_PUSH_LIT: begin
				kind_push = 1'b1;
			end
			default: begin
				// unmatched bytes are left to the core's own decode
				kind_add = 1'b0;
			end
		endcase
	end

	assign stack_ptr     = ptr_reg[N_PTR-1];
	assign dst_file_addr = i_instr_word[AW-1:0];
	// source is pointer plus offset, twelve-bit wrap
	assign src_addr     = stack_ptr + off7;
	// destination offset rides in the second word
	assign dst_idx_addr = stack_ptr + off7;
	// indirect source reads zero, both moves; rdata follows the held address
	assign move_data    = src_indirect_reg ? extended_set_enable_bit_pkg::ZERO_BYTE : i_mem_rdata;

	// the destination result is used in its own cycle; the source result is registered for the write
	indirect_addr_detect u_src_detect (
		.i_addr        (src_addr),
		.o_is_indirect (src_is_ind)
	);

	indirect_addr_detect u_dst_detect (
		.i_addr        (dst_idx_addr),
		.o_is_indirect (dst_is_ind)
	);

	// sequencing
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_reg <= extended_set_enable_bit_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				extended_set_enable_bit_pkg::ST_IDLE: begin
					if (ret_form || is_call) begin
						state_reg <= extended_set_enable_bit_pkg::ST_NOP;
					end else if (is_move) begin
						state_reg <= i_instr_word[7] ? extended_set_enable_bit_pkg::ST_MOVE_IDX : extended_set_enable_bit_pkg::ST_MOVE_FILE;
					end
				end
				extended_set_enable_bit_pkg::ST_NOP: begin
					state_reg <= extended_set_enable_bit_pkg::ST_IDLE;
				end
				extended_set_enable_bit_pkg::ST_MOVE_FILE: begin
					// waits for the second word; fetch may stall
					if (is_second) begin
						state_reg <= extended_set_enable_bit_pkg::ST_IDLE;
					end
				end
				extended_set_enable_bit_pkg::ST_MOVE_IDX: begin
					// destination offset also rides in the second word
					if (is_second) begin
						state_reg <= extended_set_enable_bit_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= extended_set_enable_bit_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// pointer registers, one process per pointer, for select values zero to two
	genvar p;
	generate
		for (p = 0; p < N_PTR; p++) begin : g_ptr
			logic is_stack;
			logic sub_here;

			assign is_stack = (p == N_PTR - 1);
			// select three also lands on the stack pointer
			assign sub_here = is_sub && ((sel == 2'(p)) || (is_stack && sel == extended_set_enable_bit_pkg::SEL_STACK_PTR));

			always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					ptr_reg[p] <= extended_set_enable_bit_pkg::PTR_RESET;
				end else if (is_stack && is_add) begin
					// add literal, wraps at twelve bits
					ptr_reg[p] <= ptr_reg[p] + lit6;
				end else if (sub_here) begin
					ptr_reg[p] <= ptr_reg[p] - lit6;
				end else if (is_stack && is_push) begin
					ptr_reg[p] <= ptr_reg[p] - AW'(1);
				end
			end
		end
	endgenerate

	// source address of a move, held for the read in the second-word cycle
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mem_raddr_reg <= extended_set_enable_bit_pkg::PTR_RESET;
		end else if (is_move) begin
			// any address in the data space
			mem_raddr_reg <= src_addr;
		end
	end

	// remembers an indirect source until the write
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			src_indirect_reg <= 1'b0;
		end else if (is_move) begin
			src_indirect_reg <= src_is_ind;
		end
	end

	// data memory writes
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mem_write_reg <= '0;
		end else begin
			// we is a pulse; address and data change only on a write or on a suppressed indexed move
			mem_write_reg.we <= 1'b0;
			if (is_push) begin
				mem_write_reg.we    <= 1'b1;
				mem_write_reg.addr  <= stack_ptr;
				mem_write_reg.wdata <= i_instr_word[7:0];
			end else if (is_second && state_reg == extended_set_enable_bit_pkg::ST_MOVE_FILE) begin
				mem_write_reg.we    <= 1'b1;
				mem_write_reg.addr  <= dst_file_addr;
				mem_write_reg.wdata <= move_data;
			end else if (is_second && state_reg == extended_set_enable_bit_pkg::ST_MOVE_IDX) begin
				mem_write_reg.we    <= !dst_is_ind;
				mem_write_reg.addr  <= dst_idx_addr;
				mem_write_reg.wdata <= move_data;
			end
		end
	end

	// program flow and return stack
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flow_reg <= '0;
		end else begin
			flow_reg.push <= 1'b0;
			flow_reg.load <= 1'b0;
			// stack top is taken now; the nop cycle only waits for the refetch
			if (ret_form) begin
				flow_reg.load       <= 1'b1;
				flow_reg.load_value <= i_return_stack_top;
			end else if (is_call) begin
				flow_reg.push       <= 1'b1;
				flow_reg.push_value <= i_program_counter + extended_set_enable_bit_pkg::PC_STEP;
				// only pc changes; no shadow save
				flow_reg.load       <= 1'b1;
				flow_reg.load_value <= {i_program_counter_upper_latch[4:0],
					i_program_counter_high_latch, i_accumulator_register};
			end
		end
	end

	// one-cycle pulse for an accepted first word
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			handled_reg <= 1'b0;
		end else begin
			// second words raise no pulse; the core already knows a move is open
			handled_reg <= is_add || is_sub || is_move || is_push || is_call;
		end
	end

	// core inserts a nop while busy
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_reg <= 1'b0;
		end else begin
			// a move stays busy until its second word, however long fetch stalls
			busy_reg <= ret_form || is_call || is_move || (in_move && !is_second);
		end
	end

	assign o_busy                   = busy_reg;
	assign o_handled                = handled_reg;
	assign o_mem_raddr              = mem_raddr_reg;
	assign o_mem_write              = mem_write_reg;
	assign o_flow                   = flow_reg;
	assign o_file_select_pointer0   = ptr_reg[0];
	assign o_file_select_pointer1   = ptr_reg[1];
	assign o_stack_pointer_register = ptr_reg[2];
endmodule

// *** extended_set_enable_bit_exec_monitor.sv ***
// port-level checker for the extended stack instruction unit
`timescale 1ns/1ps
module extended_set_enable_bit_exec_monitor (
	input wire logic                        i_sys_clk,
	input wire logic                        i_reset_n,
	input wire logic                        i_extended_set_enable_bit,
	input wire logic                        i_instr_valid,
	input wire logic [15:0]                 i_instr_word,
	input wire logic [extended_set_enable_bit_pkg::PC_W-1:0]  i_program_counter,
	input wire logic [7:0]                  i_accumulator_register,
	input wire logic [7:0]                  i_program_counter_high_latch,
	input wire logic [7:0]                  i_program_counter_upper_latch,
	input wire logic [extended_set_enable_bit_pkg::PC_W-1:0]  i_return_stack_top,
	input wire logic                        o_busy,
	input wire logic                        o_handled,
	input wire logic [extended_set_enable_bit_pkg::ADDR_W-1:0] o_mem_raddr,
	input wire extended_set_enable_bit_pkg::mem_write_t       o_mem_write,
	input wire extended_set_enable_bit_pkg::flow_t            o_flow,
	input wire logic [extended_set_enable_bit_pkg::ADDR_W-1:0] o_file_select_pointer0,
	input wire logic [extended_set_enable_bit_pkg::ADDR_W-1:0] o_stack_pointer_register
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	// busy also marks a pending move, so first words are only taken when low
	wire logic        tk  = i_instr_valid & i_extended_set_enable_bit & ~o_busy;
	wire logic [7:0]  hi  = i_instr_word[15:8];
	wire logic [7:0]  lit = i_instr_word[7:0];
	wire logic        s3  = i_instr_word[7:6] == 2'h3;
	wire logic [11:0] k12 = {6'h00, i_instr_word[5:0]};
	wire logic [11:0] z12 = {5'h00, i_instr_word[6:0]};
	wire logic [20:0] dst = {i_program_counter_upper_latch[4:0], i_program_counter_high_latch, i_accumulator_register};
	wire logic        cw  = tk && i_instr_word == 16'h0014;
	push_step_a: assert property (tk && hi == 8'hFA |=> o_mem_write.we && o_mem_write.addr == $past(o_stack_pointer_register)
		&& o_mem_write.wdata == $past(lit) && o_stack_pointer_register == $past(o_stack_pointer_register) - 12'h001)
		else $error("push literal wrong");
	add_return_a: assert property (tk && hi == 8'hE8 && s3 |=> o_flow.load && o_flow.load_value == $past(i_return_stack_top)
		&& o_stack_pointer_register == $past(o_stack_pointer_register) + $past(k12)) else $error("add and return wrong");
	ret_two_cycle_a: assert property (tk && (hi == 8'hE8 || hi == 8'hE9) && s3 |=> o_busy ##1 !o_busy && !o_flow.load)
		else $error("return not two cycles");
	call_target_a: assert property (cw |=> o_flow.push && o_flow.push_value == $past(i_program_counter) + 21'h000002
		&& o_flow.load && o_flow.load_value == $past(dst)) else $error("call target wrong");
	call_nop_a: assert property (cw |=> o_busy && !o_mem_write.we ##1 !o_busy && !o_flow.push)
		else $error("call second cycle wrong");
	sub_ptr_a: assert property (tk && hi == 8'hE9 && i_instr_word[7:6] == 2'h0 |=> !o_busy
		&& o_file_select_pointer0 == $past(o_file_select_pointer0) - $past(k12)) else $error("pointer subtract wrong");
	sub_return_a: assert property (tk && hi == 8'hE9 && s3 |=> o_flow.load
		&& o_stack_pointer_register == $past(o_stack_pointer_register) - $past(k12)) else $error("subtract return wrong");
	move_source_a: assert property (tk && hi == 8'hEB |=> o_busy
		&& o_mem_raddr == $past(o_stack_pointer_register) + $past(z12)) else $error("move source wrong");
	set_off_a: assert property (i_instr_valid && !i_extended_set_enable_bit |=> !o_handled && !o_mem_write.we)
		else $error("disabled word acted on");
endmodule
bind extended_stack_instruction_exec extended_set_enable_bit_exec_monitor u_mon (.*);

// *** data_mem_model.sv ***
// data memory model facing the execute unit
`timescale 1ns/1ps
module data_mem_model (
	input  wire logic                          i_sys_clk,
	input  wire extended_set_enable_bit_pkg::mem_write_t         i_mem_write,
	input  wire logic [extended_set_enable_bit_pkg::ADDR_W-1:0]  i_mem_raddr,
	output logic [7:0]                         o_mem_rdata
);
	logic [7:0] mem [4096];
	initial begin
		for (int a = 0; a < 4096; a++) begin
			mem[a] = a[7:0] ^ 8'h5A;
		end
	end
	always @(posedge i_sys_clk) begin
		if (i_mem_write.we) begin
			mem[i_mem_write.addr] <= i_mem_write.wdata;
		end
	end
	assign o_mem_rdata = mem[i_mem_raddr];
endmodule

// *** extended_stack_instruction_exec_tb_top.sv ***
// self-checking bench for the extended stack instruction unit
`timescale 1ns/1ps
module extended_stack_instruction_exec_tb_top;
	logic clk, rst_n, en, vld, busy, handled;
	logic [15:0] word;
	logic [20:0] pc, return_stack_top;
	logic [7:0]  acc, lh, lu, rdata;
	logic [11:0] raddr, p0, p1, sp;
	extended_set_enable_bit_pkg::mem_write_t mw;
	extended_set_enable_bit_pkg::flow_t      fl;
	int bad_count = 0;
	int n_tests = 0;
	extended_stack_instruction_exec u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_extended_set_enable_bit(en),
		.i_instr_valid(vld), .i_instr_word(word), .i_program_counter(pc), .i_accumulator_register(acc),
		.i_program_counter_high_latch(lh), .i_program_counter_upper_latch(lu), .i_return_stack_top(return_stack_top),
		.i_mem_rdata(rdata), .o_busy(busy), .o_handled(handled), .o_mem_raddr(raddr), .o_mem_write(mw),
		.o_flow(fl), .o_file_select_pointer0(p0), .o_file_select_pointer1(p1), .o_stack_pointer_register(sp));
	data_mem_model u_mem (.i_sys_clk(clk), .i_mem_write(mw), .i_mem_raddr(raddr), .o_mem_rdata(rdata));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [15:0] w);
		vld = 1'b1;
		word = w;
		@(negedge clk);
	endtask
	task automatic idle;
		vld = 1'b0;
		@(negedge clk);
	endtask
	task automatic t_push;
		op(16'hFA08);
		chk({mw, handled, sp}, {1'b1, 12'h000, 8'h08, 1'b1, 12'hFFF});
		op(16'hFA77);
		chk({mw, sp}, {1'b1, 12'hFFF, 8'h77, 12'hFFE});
	endtask
	task automatic t_ret;
		op(16'hE8C5);
		chk({fl.load, fl.load_value, busy, sp}, {1'b1, return_stack_top, 1'b1, 12'h003});
		idle;
		chk({fl.load, busy}, 2'b00);
		op(16'hE9C3);
		chk({fl.load, fl.load_value, sp}, {1'b1, return_stack_top, 12'h000});
		idle;
	endtask
	task automatic t_sub;
		for (int f = 0; f < 3; f++) begin
			op({8'hE9, f[1:0], 6'h01});
		end
		chk({p0, p1, sp, busy}, {12'hFFF, 12'hFFF, 12'hFFF, 1'b0});
	endtask
	task automatic t_call;
		op(16'h0014);
		chk({fl.push, fl.push_value, fl.load, fl.load_value, mw.we}, {1'b1, 21'h012342, 1'b1, 21'h001006, 1'b0});
		// word offered in the fill cycle must be dropped
		op(16'hFA11);
		chk({mw.we, busy, sp}, {1'b0, 1'b0, 12'hFFF});
		idle;
	endtask
	task automatic t_move;
		op(16'hEB05);
		chk({raddr, busy}, {12'h004, 1'b1});
		idle;
		op(16'hF123);
		chk({mw, busy}, {1'b1, 12'h123, 8'h5E, 1'b0});
		op(16'hE9FF);
		idle;
		op(16'hEBAF);
		chk({raddr, sp}, {12'hFEF, 12'hFC0});
		op(16'hF005);
		chk(mw, {1'b1, 12'hFC5, 8'h00});
		op(16'hEB86);
		op(16'hF01F);
		chk({mw.we, busy}, 2'b00);
		op(16'hEB2F);
		op(16'hF200);
		chk(mw, {1'b1, 12'h200, 8'h00});
		idle;
	endtask
	task automatic t_off;
		en = 1'b0;
		op(16'hFA55);
		chk({mw.we, handled, sp}, {1'b0, 1'b0, 12'hFC0});
		en = 1'b1;
		idle;
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		rst_n = 1'b0;
		en = 1'b1;
		vld = 1'b0;
		word = 16'h0000;
		pc = 21'h012340;
		return_stack_top = 21'h0ABCDE;
		acc = 8'h06;
		lh = 8'h10;
		// upper bits of the upper latch are dropped
		lu = 8'hE0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		t_push;
		t_ret;
		t_sub;
		t_call;
		t_move;
		t_off;
		final_report;
	end
	initial begin
		#200000;
		bad_count++;
		final_report;
	end
endmodule
